// file: verilog/sac_defines.svh
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// structure of the converter
`define SAC_DATA_W       8
`define SAC_CHANNELS     8
`define SAC_ADDR_W       3
// analog inputs are digital levels in half-LSB units
`define SAC_IN_W         9
`define SAC_SYNC_STAGES  2

// reset values
`define SAC_RESULT_RST   8'h00
`define SAC_APPROX_RST   8'h00
`define SAC_CHAN_RST     3'h0
`define SAC_SELECT_RST   8'h01
`define SAC_DONE_RST     1'b0

`endif

// file: verilog/sac_pkg.sv
// types shared by the converter control files
package sac_pkg;

    // conversion phases, gray coded along idle, armed, convert, finish
    typedef enum logic [1:0] {
        SAC_IDLE    = 2'b00,
        SAC_ARMED   = 2'b01,
        SAC_CONVERT = 2'b11,
        SAC_FINISH  = 2'b10
    } sac_state_t;

endpackage

// file: verilog/sac_sync.sv
`timescale 1ns/100ps
// multi-stage synchroniser for pins from outside the clock domain
module sac_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // fewer than two stages would not be a synchroniser
    if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
        $error("sac_sync needs at least two stages and one bit");
    end

    logic [STAGES-1:0][WIDTH-1:0] stage_q;  // stage 0 read only by stage 1

    // shift the pins through the stages
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            stage_q <= '0;
        end else begin
            stage_q[0] <= async_i;
            for (int i = 1; i < STAGES; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign sync_o = stage_q[STAGES-1];

endmodule

// file: verilog/sac_converter_control.sv
`timescale 1ns/100ps
`include "sac_defines.svh"
// control logic of an 8-bit successive approximation converter with channel selector
module sac_converter_control
    import sac_pkg::*;
#(
    parameter int CHANNELS    = `SAC_CHANNELS,
    parameter int ADDR_W      = `SAC_ADDR_W,
    parameter int DATA_W      = `SAC_DATA_W,
    parameter int IN_W        = `SAC_IN_W,
    parameter int SYNC_STAGES = `SAC_SYNC_STAGES
) (
    input  wire logic                     clock_i,              // 50 mhz system clock
    input  wire logic                     reset_i,              // async, active high
    input  wire logic [ADDR_W-1:0]        channel_address_i,    // bit 2 is line c
    input  wire logic                     address_latch_i,      // latch strobe pin
    input  wire logic                     conversion_trigger_i, // start pin
    input  wire logic                     conversion_clock_i,   // conversion clock pin
    input  wire logic [CHANNELS*IN_W-1:0] analog_inputs_i,      // channel 0 in low bits
    output logic      [DATA_W-1:0]        result_o,             // output data register
    output logic                          conversion_done_o,    // end of conversion
    output logic      [ADDR_W-1:0]        channel_o,            // latched channel code
    output logic      [CHANNELS-1:0]      channel_select_o,     // one-hot decoder output
    output sac_pkg::sac_state_t           phase_o               // conversion phase
);

    import sac_pkg::*;

    // the decoder and the comparator only serve these shapes
    if (CHANNELS != (1 << ADDR_W)) begin : g_bad_channels
        $error("channel count must equal two to the address width");
    end
    if (IN_W != DATA_W + 1 || DATA_W < 2) begin : g_bad_widths
        $error("input width must be result width plus one half-LSB bit");
    end

    localparam int IDX_W  = $clog2(DATA_W);
    localparam int SYNC_W = ADDR_W + 3 + CHANNELS * IN_W;

    localparam logic [IDX_W-1:0]  IDX_MSB  = IDX_W'(DATA_W - 1);  // first bit decided
    localparam logic [IDX_W-1:0]  IDX_LSB  = '0;                  // last bit decided
    localparam logic [DATA_W-1:0] ONE_BIT  = DATA_W'(1);          // mask seed
    localparam logic [IN_W-1:0]   HALF_LSB = IN_W'(1);            // one half-LSB unit

    // pin synchronisation
    // one shared synchroniser keeps every pin aligned to the same edge

    logic [SYNC_W-1:0]        sync_raw;     // all pins after the synchroniser
    logic [ADDR_W-1:0]        addr_s;       // synchronised address lines
    logic                     latch_s;      // synchronised latch strobe
    logic                     trigger_s;    // synchronised start pin
    logic                     cclk_s;       // synchronised conversion clock
    logic [CHANNELS*IN_W-1:0] analog_s;     // synchronised input levels

    // every pin crosses two flip-flops before any logic looks at it
    sac_sync #(
        .WIDTH  (SYNC_W),
        .STAGES (SYNC_STAGES)
    ) u_pin_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i ({channel_address_i, address_latch_i, conversion_trigger_i,
                   conversion_clock_i, analog_inputs_i}),
        .sync_o  (sync_raw)
    );

    // split the synchronised word back into its pins
    assign {addr_s, latch_s, trigger_s, cclk_s, analog_s} = sync_raw;

    // edge detection
    // reset levels match the idle pins, so no false edge follows reset

    logic latch_prev_q;    // strobe one cycle ago
    logic trigger_prev_q;  // start pin one cycle ago
    logic cclk_prev_q;     // conversion clock one cycle ago

    // remember the previous synchronised levels
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            latch_prev_q   <= 1'b0;
            trigger_prev_q <= 1'b0;
            cclk_prev_q    <= 1'b0;
        end else begin
            latch_prev_q   <= latch_s;
            trigger_prev_q <= trigger_s;
            cclk_prev_q    <= cclk_s;
        end
    end

    wire latch_rise   = latch_s & ~latch_prev_q;      // strobe low to high
    wire trigger_rise = trigger_s & ~trigger_prev_q;  // start low to high
    wire trigger_fall = ~trigger_s & trigger_prev_q;  // start high to low
    wire cclk_rise    = cclk_s & ~cclk_prev_q;        // one conversion clock pulse

    // channel address latch and decoder
    // address and strobe pass the same stages, so they stay lined up

    logic [ADDR_W-1:0]   chan_q;     // latched channel code
    logic [CHANNELS-1:0] select_q;   // latched one-hot selection
    logic [CHANNELS-1:0] decode;     // decoder on the live address

    // binary code, line c weighs most, code 0 picks input 0
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_decode
        assign decode[ch] = (addr_s == ADDR_W'(ch));
    end

    // capture on the strobe rising edge and hold until the next one
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            chan_q   <= `SAC_CHAN_RST;
            select_q <= `SAC_SELECT_RST;
        end else if (latch_rise) begin
            chan_q   <= addr_s;
            select_q <= decode;
        end
    end

    // level of the selected input, in half-LSB units
    wire [IN_W-1:0] selected_level = analog_s[chan_q*IN_W +: IN_W];

    // trial level and comparator
    // levels sit in half-LSB units, which keeps the comparison exact

    sac_state_t        state_q;     // conversion phase
    sac_state_t        state_d;
    logic [DATA_W-1:0] approx_q;    // approximation register
    logic [DATA_W-1:0] approx_d;
    logic [IDX_W-1:0]  bit_idx_q;   // bit under trial
    logic [IDX_W-1:0]  bit_idx_d;
    logic [DATA_W-1:0] result_q;    // output data register
    logic [DATA_W-1:0] result_d;
    logic              done_q;      // end-of-conversion flag
    logic              done_d;

    // trial code is the decided bits plus the bit under trial
    wire [DATA_W-1:0] bit_mask = ONE_BIT << bit_idx_q;
    wire [DATA_W-1:0] trial    = approx_q | bit_mask;

    // code k begins at k LSB minus half an LSB, so offset by one half unit
    wire [IN_W-1:0] threshold = {trial, 1'b0} - HALF_LSB;

    // keep the trial bit only while its threshold does not exceed the input
    wire keep_bit = (threshold <= selected_level);

    // register value after the current step
    wire [DATA_W-1:0] approx_step = keep_bit ? trial : approx_q;

    // conversion sequencer
    // conversion clock edges are sampled here, never used as a clock

    // next-state logic; a start rising edge overrides every phase
    always_comb begin
        state_d   = state_q;
        approx_d  = approx_q;
        bit_idx_d = bit_idx_q;
        result_d  = result_q;
        done_d    = done_q;
        if (trigger_rise) begin
            // clear and wait for the falling edge, even mid-conversion
            state_d   = SAC_ARMED;
            approx_d  = `SAC_APPROX_RST;
            bit_idx_d = IDX_MSB;
            done_d    = 1'b0;
        end else begin
            unique case (state_q)
                SAC_IDLE: begin
                    // holding the last result; done high after a conversion, low after reset
                end
                SAC_ARMED: begin
                    // approximation begins only when the pulse ends
                    if (trigger_fall) begin
                        state_d   = SAC_CONVERT;
                        bit_idx_d = IDX_MSB;
                    end
                end
                SAC_CONVERT: begin
                    // one bit decided per conversion clock, MSB first
                    if (cclk_rise) begin
                        approx_d = approx_step;
                        if (bit_idx_q == IDX_LSB) begin
                            // eighth step: load the data register now
                            result_d = approx_step;
                            state_d  = SAC_FINISH;
                        end else begin
                            bit_idx_d = bit_idx_q - IDX_W'(1);
                        end
                    end
                end
                SAC_FINISH: begin
                    // done rises one conversion clock after the load
                    if (cclk_rise) begin
                        done_d  = 1'b1;
                        state_d = SAC_IDLE;
                    end
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_q   <= SAC_IDLE;
            approx_q  <= `SAC_APPROX_RST;
            bit_idx_q <= '0;
            result_q  <= `SAC_RESULT_RST;
            done_q    <= `SAC_DONE_RST;
        end else begin
            state_q   <= state_d;
            approx_q  <= approx_d;
            bit_idx_q <= bit_idx_d;
            result_q  <= result_d;
            done_q    <= done_d;
        end
    end

    // outputs, each straight from a flip-flop
    // no output depends on a live pin, so none can glitch

    // result bits high mean one: positive-true binary
    assign result_o          = result_q;
    assign conversion_done_o = done_q;
    assign channel_o         = chan_q;
    assign channel_select_o  = select_q;
    assign phase_o           = state_q;

endmodule

// file: verif/sac_properties.sv
`timescale 1ns/100ps
// timing relations at the converter control ports
module sac_properties
    import sac_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int ADDR_W   = 3,
    parameter int DATA_W   = 8,
    parameter int IN_W     = 9
) (
    input wire logic                     clock_i,
    input wire logic                     reset_i,
    input wire logic [ADDR_W-1:0]        channel_address_i,
    input wire logic                     address_latch_i,
    input wire logic                     conversion_trigger_i,
    input wire logic                     conversion_clock_i,
    input wire logic [CHANNELS*IN_W-1:0] analog_inputs_i,
    input wire logic [DATA_W-1:0]        result_o,
    input wire logic                     conversion_done_o,
    input wire logic [ADDR_W-1:0]        channel_o,
    input wire logic [CHANNELS-1:0]      channel_select_o,
    input wire sac_pkg::sac_state_t      phase_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // pins reach the logic three edges after they are sampled
    a_channel_latch: assert property (
        $rose(address_latch_i) |-> ##3 channel_o == $past(channel_address_i, 3))
        else $error("channel code not latched");
    a_channel_hold: assert property (
        !$stable(channel_o) |-> $past(address_latch_i, 3) && !$past(address_latch_i, 4))
        else $error("channel changed without strobe");
    a_select_onehot: assert property (
        channel_select_o == (CHANNELS'(1) << channel_o))
        else $error("decoder output wrong");
    a_trigger_arms: assert property (
        $rose(conversion_trigger_i) |-> ##3 (phase_o == SAC_ARMED && !conversion_done_o))
        else $error("trigger rise did not arm");
    a_fall_starts: assert property (
        $fell(conversion_trigger_i) && phase_o == SAC_ARMED |-> ##3 phase_o == SAC_CONVERT)
        else $error("trigger fall did not start");
    a_done_low_busy: assert property (
        phase_o != SAC_IDLE |-> !conversion_done_o)
        else $error("done high while busy");
    a_result_on_load: assert property (
        !$stable(result_o) |-> phase_o == SAC_FINISH && $past(phase_o) == SAC_CONVERT)
        else $error("result changed outside load");
    a_done_after_load: assert property (
        $rose(conversion_done_o) |-> $past(phase_o) == SAC_FINISH && phase_o == SAC_IDLE)
        else $error("done rose without load");
    c_abort: cover property ($rose(conversion_trigger_i) && phase_o == SAC_CONVERT);
    c_done: cover property ($rose(conversion_done_o));
    c_latch: cover property ($rose(address_latch_i));
endmodule

bind sac_converter_control sac_properties #(
    .CHANNELS (CHANNELS), .ADDR_W (ADDR_W), .DATA_W (DATA_W), .IN_W (IN_W)
) u_props (
    .clock_i (clock_i), .reset_i (reset_i), .channel_address_i (channel_address_i),
    .address_latch_i (address_latch_i), .conversion_trigger_i (conversion_trigger_i),
    .conversion_clock_i (conversion_clock_i), .analog_inputs_i (analog_inputs_i),
    .result_o (result_o), .conversion_done_o (conversion_done_o), .channel_o (channel_o),
    .channel_select_o (channel_select_o), .phase_o (phase_o));

// file: verif/sac_host_model.sv
`timescale 1ns/100ps
// host side: makes the conversion clock and the start line
module sac_host_model #(
    parameter int HALF = 3 // cycles per conversion clock level
) (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic pulse_i,             // start request from the bench
    input  wire logic loop_i,              // free-running wiring
    input  wire logic done_i,              // end of conversion
    output logic      conversion_clock_o,  // conversion clock pin
    output logic      conversion_trigger_o // start pin
);
    logic [3:0] div_q; // level length counter
    // slow conversion clock, each level several system clocks long
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            div_q              <= 4'h0;
            conversion_clock_o <= 1'b0;
        end else if (div_q == 4'(HALF - 1)) begin
            div_q              <= 4'h0;
            conversion_clock_o <= ~conversion_clock_o;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    // loopback hands done straight back as the start level
    assign conversion_trigger_o = loop_i ? done_i : pulse_i;
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
// self-checking bench for the converter control
module tb;
    import sac_pkg::*;
    localparam logic [8:0] CORNER [6] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h1fe, 9'h1ff};
    logic        clock_i = 1'b0; // system clock
    logic        reset_i = 1'b1; // async reset
    logic [2:0]  addr    = 3'h0; // channel code
    logic        strobe  = 1'b0; // latch strobe
    logic        pulse   = 1'b0; // start request
    logic        loop    = 1'b0; // free-running wiring
    logic [71:0] ain     = '0;   // eight levels
    logic [7:0]  result, sel;
    logic [2:0]  chan;
    logic        done, trig, cclk;
    sac_state_t  phase;
    int          bad_count = 0;
    int          compares  = 0;
    int          cycles    = 0;
    always #10 clock_i = ~clock_i;
    sac_converter_control u_dut (
        .clock_i (clock_i), .reset_i (reset_i), .channel_address_i (addr),
        .address_latch_i (strobe), .conversion_trigger_i (trig),
        .conversion_clock_i (cclk), .analog_inputs_i (ain), .result_o (result),
        .conversion_done_o (done), .channel_o (chan), .channel_select_o (sel),
        .phase_o (phase));
    sac_host_model u_host (
        .clock_i (clock_i), .reset_i (reset_i), .pulse_i (pulse), .loop_i (loop),
        .done_i (done), .conversion_clock_o (cclk), .conversion_trigger_o (trig));
    // hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic tick(int n = 1);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // code for a level in half-LSB units
    function automatic logic [7:0] expect_code(logic [8:0] lvl);
        return (lvl == 9'h1ff) ? 8'hff : 8'((lvl + 9'h1) >> 1);
    endfunction
    task automatic select(logic [2:0] ch);
        addr = ch;
        tick(2);
        strobe = 1'b1;
        tick(3);
        strobe = 1'b0;
        tick(3);
        check("channel", {5'h0, ch}, {5'h0, chan});
        check("select", 8'h01 << ch, sel);
    endtask
    task automatic start();
        pulse = 1'b1;
        tick(4);
        check("done low", 8'h00, {7'h0, done});
        pulse = 1'b0;
    endtask
    task automatic finish(logic [7:0] exp);
        int n = 0;
        while (done !== 1'b1 && n < 400) begin
            tick();
            n++;
        end
        check("done high", 8'h01, {7'h0, done});
        check("result", exp, result);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        logic [8:0] lvl;
        logic [2:0] ch;
        void'($urandom(46));
        tick(3);
        reset_i = 1'b0;
        // every channel code, corner levels first, then random ones
        for (int i = 0; i < 14; i++) begin
            ch  = (i < 8) ? 3'(i) : 3'($urandom);
            lvl = (i < 6) ? CORNER[i] : 9'($urandom);
            ain = 72'({$urandom, $urandom, $urandom});
            ain[ch*9 +: 9] = lvl;
            select(ch);
            start();
            finish(expect_code(lvl));
            $display("test %0d done", i);
        end
        // restart in mid-conversion with a new level
        ain[8:0] = 9'h1ff;
        select(3'h0);
        start();
        tick(20);
        check("phase", 8'(SAC_CONVERT), 8'(phase));
        lvl = 9'($urandom);
        ain[8:0] = lvl;
        start();
        finish(expect_code(lvl));
        $display("test abort done");
        // free-running: one start pulse, then done drives the start line
        start();
        loop = 1'b1;
        repeat (3) begin
            finish(expect_code(lvl));
            tick(4);
            check("restart", 8'h00, {7'h0, done});
        end
        loop = 1'b0;
        $display("test loop done");
        final_report();
    end
endmodule
